/* testbench.sv */
// Self-checking bench for the transmit packet-handler control slice.
// Assumes txph_params.svh constants; expected bytes queue per packet.
`timescale 1ns/1ps
`include "txph_params.svh"
module testbench;
    import txph_pkg::*;
    logic clk, rst_n, regWrEn, regRdEn, txStart, fifoInValid;
    logic fifoInReady, txBit, txBitStrobe, pktSentEvent, lsbFirst;
    logic [6:0] regAddr;
    logic [1:0] modSource;
    txph_byte_t regWrData, regRdData, payloadLen, fifoInData, shReg, expB;
    txph_byte_t expQ[$];
    logic [15:0] polys [4] = '{`TXPH_POLY_CCITT, `TXPH_POLY_IBM, `TXPH_POLY_IEC, `TXPH_POLY_BAICH};
    int mismatches = 0, cmp_count = 0, cycCnt = 0, bitCnt = 0, seed = 19;
    txph_packet_handler i_txph_packet_handler (.clk, .rst_n, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .modSource, .payloadLen, .txStart, .fifoInData,
        .fifoInValid, .fifoInReady, .txBit, .txBitStrobe, .pktSentEvent);
    txph_host_model i_host (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] p,
            input logic [7:0] b, input logic lsb);
        logic d;
        for (int k = 0; k < 8; k++) begin
            d = c[15] ^ (lsb ? b[k] : b[7-k]);
            c = {c[14:0], 1'b0} ^ (d ? p : 16'h0000);
        end
        return c;
    endfunction : crcStep
    // A byte with nothing queued counts against the result
    always @(posedge clk) begin
        cycCnt++;
        if (cycCnt == 60000) begin
            mismatches++;
            print_verdict();
        end
        if (rst_n && txBitStrobe) begin
            shReg = lsbFirst ? {txBit, shReg[7:1]} : {shReg[6:0], txBit};
            bitCnt++;
            if (bitCnt == 8) begin
                bitCnt = 0;
                expB = expQ.size() ? expQ.pop_front() : ~shReg;
                chk(shReg, expB);
            end
        end
    end
    task automatic send(input logic [7:0] cfg, input logic [1:0] src, input int n);
        logic [15:0] c;
        logic [7:0] b;
        logic fr;
        fr = cfg[3] && src == 2'b10;
        c = `TXPH_CRC_INIT;
        lsbFirst = cfg[6];
        i_host.wr(7'h30, cfg);
        modSource <= src;
        payloadLen <= 8'(n);
        if (fr) begin
            repeat (4) expQ.push_back(`TXPH_PREAMBLE_BYTE);
            expQ.push_back(`TXPH_SYNC_HI);
            expQ.push_back(`TXPH_SYNC_LO);
            if (!cfg[5])
                c = crcStep(crcStep(c, polys[cfg[1:0]], `TXPH_SYNC_HI, cfg[6]),
                    polys[cfg[1:0]], `TXPH_SYNC_LO, cfg[6]);
        end
        for (int k = 0; k < n; k++) begin
            b = 8'($random(seed));
            fifoInData <= b;
            fifoInValid <= 1'b1;
            @(posedge clk);
            while (fifoInReady !== 1'b1) @(posedge clk);
            expQ.push_back(b);
            c = crcStep(c, polys[cfg[1:0]], b, cfg[6]);
        end
        fifoInValid <= 1'b0;
        fifoInData <= ~b;
        @(posedge clk);
        if (n == 8)
            chk({7'h00, fifoInReady}, 8'h00);
        if (fr && cfg[2]) begin
            expQ.push_back(c[15:8]);
            expQ.push_back(c[7:0]);
        end
        txStart <= 1'b1;
        @(posedge clk);
        txStart <= 1'b0;
        i_host.rd(7'h31, b);
        chk(b, 8'h02);
        while (pktSentEvent !== 1'b1) @(posedge clk);
        i_host.rd(7'h31, b);
        chk(b, 8'h01);
        i_host.rd(7'h31, b);
        chk(b, 8'h01);
        chk(8'(expQ.size()), 8'h00);
    endtask : send
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0] r, v;
        rst_n = 1'b0;
        txStart = 1'b0;
        fifoInValid = 1'b0;
        fifoInData = 8'h00;
        modSource = 2'b00;
        payloadLen = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        i_host.rd(7'h31, r);
        chk(r, 8'h00);
        i_host.rd(7'h30, r);
        chk(r, 8'h00);
        i_host.wr(7'h31, 8'hff);
        i_host.rd(7'h31, r);
        chk(r, 8'h00);
        i_host.rd(7'h55, r);
        chk(r, 8'h00);
        v = 8'($random(seed));
        i_host.wr(7'h30, v);
        i_host.rd(7'h30, r);
        chk(r, v);
        send(8'h00, 2'b10, 3);
        send(8'h0c, 2'b01, 8);
        for (int i = 0; i < 8; i++)
            send({1'b0, i[2], ^i[1:0], 2'b11, i != 7, i[1:0]}, 2'b10, 4);
        print_verdict();
    end
endmodule : testbench
bind txph_packet_handler txph_packet_handler_properties i_props (.clk, .rst_n, .regWrEn,
    .regRdEn, .regAddr, .regWrData, .regRdData, .modSource, .payloadLen, .txStart,
    .fifoInData, .fifoInValid, .fifoInReady, .txBit, .txBitStrobe, .pktSentEvent);

/* txph_host_model.sv */
// Host controller model on the register strobe interface.
// Assumes the caller is at a rising edge; one request at a time.
`timescale 1ns/1ps
module txph_host_model (
    input  wire logic                 clk,
    output logic                      regWrEn,
    output logic                      regRdEn,
    output logic [6:0]                regAddr,
    output txph_pkg::txph_byte_t      regWrData,
    input  wire txph_pkg::txph_byte_t regRdData
);
    import txph_pkg::*;
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 7'h00;
        regWrData = 8'h00;
    end
    // framing bit written as the caller pairs it with the source
    // Released lines show the inverse so stale values are not trusted
    task automatic wr(input logic [6:0] a, input txph_byte_t d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr
    task automatic rd(input logic [6:0] a, output txph_byte_t d);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(posedge clk);
        d = regRdData;
    endtask : rd
endmodule : txph_host_model

/* txph_packet_handler.sv */
// Transmit packet-handler control: access-control and status registers,
// an 8-word byte FIFO and a serialiser with optional framing and CRC.
// Assumes a single 40 MHz clock, synchronous register strobes from the
// serial interface, and a modulator that takes one bit per txBitStrobe.
`timescale 1ns/1ps
`include "txph_params.svh"

// ************************************************************
// Byte FIFO
// ************************************************************
module txph_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [AW:0]      count_reg, count_next;
    logic             space_reg, space_next, empty_reg, empty_next;
    logic             doWr, doRd;

    // Space and empty are registered so ready/valid seen outside come from flops
    always_comb begin
        doWr       = inValid && space_reg;
        doRd       = outReady && !empty_reg;
        wrPtr_next = doWr ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
        rdPtr_next = doRd ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
        count_next = count_reg;
        if (doWr && !doRd) begin
            count_next = (AW+1)'(count_reg + 1'b1);
        end else if (doRd && !doWr) begin
            count_next = (AW+1)'(count_reg - 1'b1);
        end
        space_next = (count_next != (AW+1)'(DEPTH));
        empty_next = (count_next == '0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            // Not ready in reset, so no byte lands before the pointers settle
            space_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
            space_reg <= space_next;
            empty_reg <= empty_next;
        end
    end

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    assign inReady  = space_reg;
    assign outValid = !empty_reg;
    assign outData  = mem[rdPtr_reg];
endmodule : txph_fifo

module txph_packet_handler (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                regWrEn,
    input  wire logic                regRdEn,
    input  wire logic [6:0]          regAddr,
    input  wire txph_pkg::txph_byte_t regWrData,
    output txph_pkg::txph_byte_t     regRdData,
    input  wire logic [1:0]          modSource,
    input  wire txph_pkg::txph_byte_t payloadLen,
    input  wire logic                txStart,
    input  wire txph_pkg::txph_byte_t fifoInData,
    input  wire logic                fifoInValid,
    output logic                     fifoInReady,
    output logic                     txBit,
    output logic                     txBitStrobe,
    output logic                     pktSentEvent
);
    import txph_pkg::*;

    localparam int DIV_W = $clog2(`TXPH_BIT_DIV);

    txph_state_e state_reg, state_next;
    txph_byte_t  access_reg, access_next, rdData_reg, rdData_next;
    txph_byte_t  shift_reg, shift_next, cnt_reg, cnt_next;
    txph_crc_t   crc_reg, crc_next, crcSnap_reg, crcSnap_next, poly;
    logic [2:0]  bitIdx_reg, bitIdx_next;
    logic [DIV_W-1:0] div_reg, div_next;
    logic        have_reg, have_next, crcByte_reg, crcByte_next;
    logic        sent_reg, sent_next, txBit_reg, txBit_next;
    logic        strobe_reg, strobe_next, event_reg, event_next;
    logic        bitEn, framed, curBit, pop, fbk;
    txph_byte_t  fifoOutData;
    logic        fifoOutValid, fifoReady;

    // ************************************************************
    // Data buffer
    // ************************************************************
    txph_fifo #(
        .WIDTH (`TXPH_BYTE_W),
        .DEPTH (`TXPH_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inData   (fifoInData),
        .inValid  (fifoInValid),
        .inReady  (fifoReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (pop)
    );

    // ************************************************************
    // Bit-rate divider and framer
    // ************************************************************
    // framing gate
    assign framed = access_reg[`TXPH_BIT_FRAME_EN] && (modSource == `TXPH_SRC_FIFO);
    assign bitEn  = (div_reg == DIV_W'(`TXPH_BIT_DIV - 1));
    assign curBit = access_reg[`TXPH_BIT_LSBFIRST] ? shift_reg[bitIdx_reg]
                                                    : shift_reg[3'h7 - bitIdx_reg];

    always_comb begin
        case (access_reg[`TXPH_POLY_HI:`TXPH_POLY_LO])
            2'h0:    poly = `TXPH_POLY_CCITT;
            2'h1:    poly = `TXPH_POLY_IBM;
            2'h2:    poly = `TXPH_POLY_IEC;
            default: poly = `TXPH_POLY_BAICH;
        endcase
    end

    always_comb begin
        state_next   = state_reg;
        shift_next   = shift_reg;
        cnt_next     = cnt_reg;
        crc_next     = crc_reg;
        crcSnap_next = crcSnap_reg;
        bitIdx_next  = bitIdx_reg;
        have_next    = have_reg;
        crcByte_next = crcByte_reg;
        sent_next    = sent_reg;
        txBit_next   = txBit_reg;
        strobe_next  = 1'b0;
        event_next   = 1'b0;
        pop          = 1'b0;
        fbk          = curBit ^ crc_reg[15];
        div_next     = bitEn ? '0 : DIV_W'(div_reg + 1'b1);
        if (have_reg && bitEn) begin
            txBit_next  = curBit;
            strobe_next = 1'b1;
            bitIdx_next = 3'(bitIdx_reg + 1'b1);
            have_next   = (bitIdx_reg != 3'h7);
            if (crcByte_reg) begin
                crc_next = fbk ? ((crc_reg << 1) ^ poly) : (crc_reg << 1);
            end
        end
        if (!have_reg) begin
            case (state_reg)
                TXPH_IDLE: begin
                    if (txStart) begin
                        // raw path when framing is off
                        state_next = framed ? TXPH_PRE : TXPH_RAW;
                        cnt_next   = '0;
                        crc_next   = `TXPH_CRC_INIT;
                        sent_next  = 1'b0;
                    end
                end
                TXPH_PRE: begin
                    if (cnt_reg < 8'(`TXPH_PREAMBLE_NUM)) begin
                        shift_next   = `TXPH_PREAMBLE_BYTE;
                        have_next    = 1'b1;
                        crcByte_next = 1'b0;
                        cnt_next     = 8'(cnt_reg + 1'b1);
                    end else begin
                        state_next = TXPH_SYNC;
                        cnt_next   = '0;
                    end
                end
                TXPH_SYNC: begin
                    if (cnt_reg < 8'(`TXPH_SYNC_NUM)) begin
                        shift_next = (cnt_reg == '0) ? `TXPH_SYNC_HI : `TXPH_SYNC_LO;
                        have_next  = 1'b1;
                        // scope: sync bytes excluded when payload-only
                        crcByte_next = access_reg[`TXPH_BIT_CRC_EN] &&
                                       !access_reg[`TXPH_BIT_CRCDONLY];
                        cnt_next     = 8'(cnt_reg + 1'b1);
                    end else begin
                        state_next = TXPH_PAY;
                        cnt_next   = '0;
                    end
                end
                TXPH_PAY: begin
                    if (cnt_reg < payloadLen) begin
                        // Waits on an empty FIFO rather than sending filler
                        if (fifoOutValid) begin
                            pop          = 1'b1;
                            shift_next   = fifoOutData;
                            have_next    = 1'b1;
                            crcByte_next = access_reg[`TXPH_BIT_CRC_EN];
                            cnt_next     = 8'(cnt_reg + 1'b1);
                        end
                    end else if (access_reg[`TXPH_BIT_CRC_EN]) begin
                        state_next   = TXPH_CRC;
                        crcSnap_next = crc_reg;
                        cnt_next     = '0;
                    end else begin
                        state_next = TXPH_DONE;
                    end
                end
                TXPH_CRC: begin
                    if (cnt_reg < 8'(`TXPH_CRC_NUM)) begin
                        shift_next   = (cnt_reg == '0) ? crcSnap_reg[15:8] : crcSnap_reg[7:0];
                        have_next    = 1'b1;
                        crcByte_next = 1'b0;
                        cnt_next     = 8'(cnt_reg + 1'b1);
                    end else begin
                        state_next = TXPH_DONE;
                    end
                end
                TXPH_RAW: begin
                    if (fifoOutValid) begin
                        pop          = 1'b1;
                        shift_next   = fifoOutData;
                        have_next    = 1'b1;
                        crcByte_next = 1'b0;
                    end else begin
                        state_next = TXPH_DONE;
                    end
                end
                TXPH_DONE: begin
                    sent_next  = 1'b1;
                    event_next = 1'b1;
                    state_next = TXPH_IDLE;
                end
                default: state_next = TXPH_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_comb begin
        access_next = access_reg;
        rdData_next = rdData_reg;
        if (regWrEn && regAddr == `TXPH_ADDR_ACCESS) begin
            access_next = regWrData;
        end
        if (regRdEn) begin
            case (regAddr)
                `TXPH_ADDR_ACCESS: rdData_next = access_reg;
                // transmitting bit, read has no side effect
                `TXPH_ADDR_STATUS: begin
                    rdData_next                   = 8'h00;
                    rdData_next[`TXPH_BIT_PKTX]   = (state_reg != TXPH_IDLE);
                    rdData_next[`TXPH_BIT_PKSENT] = sent_reg;
                end
                default:           rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg   <= TXPH_IDLE;
            access_reg  <= `TXPH_ACCESS_RESET;
            rdData_reg  <= 8'h00;
            shift_reg   <= 8'h00;
            cnt_reg     <= 8'h00;
            crc_reg     <= `TXPH_CRC_INIT;
            crcSnap_reg <= 16'h0000;
            bitIdx_reg  <= 3'h0;
            div_reg     <= '0;
            have_reg    <= 1'b0;
            crcByte_reg <= 1'b0;
            sent_reg    <= 1'b0;
            txBit_reg   <= 1'b0;
            strobe_reg  <= 1'b0;
            event_reg   <= 1'b0;
        end else begin
            state_reg   <= state_next;
            access_reg  <= access_next;
            rdData_reg  <= rdData_next;
            shift_reg   <= shift_next;
            cnt_reg     <= cnt_next;
            crc_reg     <= crc_next;
            crcSnap_reg <= crcSnap_next;
            bitIdx_reg  <= bitIdx_next;
            div_reg     <= div_next;
            have_reg    <= have_next;
            crcByte_reg <= crcByte_next;
            sent_reg    <= sent_next;
            txBit_reg   <= txBit_next;
            strobe_reg  <= strobe_next;
            event_reg   <= event_next;
        end
    end

    // Ready is the FIFO's own space flop, so it and the write gate never disagree
    assign fifoInReady  = fifoReady;
    assign regRdData    = rdData_reg;
    assign txBit        = txBit_reg;
    assign txBitStrobe  = strobe_reg;
    assign pktSentEvent = event_reg;
endmodule : txph_packet_handler

/* txph_packet_handler_properties.sv */
// Port checks for the transmit packet-handler control slice.
// Assumes a bind onto txph_packet_handler; one clock, rst_n sync low.
`timescale 1ns/1ps
module txph_packet_handler_properties (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 regWrEn,
    input wire logic                 regRdEn,
    input wire logic [6:0]           regAddr,
    input wire txph_pkg::txph_byte_t regWrData,
    input wire txph_pkg::txph_byte_t regRdData,
    input wire logic [1:0]           modSource,
    input wire txph_pkg::txph_byte_t payloadLen,
    input wire logic                 txStart,
    input wire txph_pkg::txph_byte_t fifoInData,
    input wire logic                 fifoInValid,
    input wire logic                 fifoInReady,
    input wire logic                 txBit,
    input wire logic                 txBitStrobe,
    input wire logic                 pktSentEvent
);
    import txph_pkg::*;
    // ************************************************************
    // Helper state and assertions
    // ************************************************************
    logic [15:0] gap_reg, gap_next;
    logic        busy_reg, busy_next;
    // Gap saturates so an idle spell never wraps into a false short gap
    always_comb begin
        gap_next  = txBitStrobe ? 16'h0000 : gap_reg + {15'h0000, gap_reg != 16'hffff};
        busy_next = pktSentEvent ? 1'b0 : (txStart ? 1'b1 : busy_reg);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_reg  <= 16'hffff;
            busy_reg <= 1'b0;
        end else begin
            gap_reg  <= gap_next;
            busy_reg <= busy_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_reset_zero: assert property ($rose(rst_n) |-> regRdData == 8'h00)
        else $error("read data not zero after reset");
    a_read_data_hold: assert property (!$stable(regRdData) |-> $past(regRdEn))
        else $error("read data changed without a read");
    a_fifo_ready_up: assert property ($rose(rst_n) |-> ##2 fifoInReady)
        else $error("fifo not ready after reset");
    a_strobe_one_cycle: assert property (txBitStrobe |=> !txBitStrobe)
        else $error("bit strobe longer than one cycle");
    a_bit_held: assert property (!txBitStrobe |-> $stable(txBit))
        else $error("serial bit changed without strobe");
    a_bit_spacing: assert property (txBitStrobe |-> gap_reg >= 16'h0027)
        else $error("bits closer than one bit period");
    a_sent_one_cycle: assert property (pktSentEvent |=> !pktSentEvent)
        else $error("sent event longer than one cycle");
    a_bits_in_packet: assert property ((txBitStrobe || pktSentEvent) |-> busy_reg)
        else $error("serial activity outside a packet");
    c_packet_sent: cover property (pktSentEvent);
    c_fifo_full: cover property (!fifoInReady ##1 !fifoInReady);
    c_read_nonzero: cover property (regRdEn ##1 regRdData != 8'h00);
endmodule : txph_packet_handler_properties

/* txph_params.svh */
// Constants of the transmit packet-handler control slice.
// Assumes inclusion by txph_pkg.sv, the design file and the bench.
`ifndef TXPH_PARAMS_SVH
`define TXPH_PARAMS_SVH

`define TXPH_ADDR_ACCESS   7'h30
`define TXPH_ADDR_STATUS   7'h31
`define TXPH_ACCESS_RESET  8'h00
`define TXPH_BIT_LSBFIRST  6
`define TXPH_BIT_CRCDONLY  5
`define TXPH_BIT_FRAME_EN  3
`define TXPH_BIT_CRC_EN    2
`define TXPH_POLY_HI       1
`define TXPH_POLY_LO       0
`define TXPH_BIT_PKTX      1
`define TXPH_BIT_PKSENT    0
`define TXPH_SRC_FIFO      2'h2
`define TXPH_POLY_CCITT    16'h1021
`define TXPH_POLY_IBM      16'h8005
`define TXPH_POLY_IEC      16'h3d65
`define TXPH_POLY_BAICH    16'h8bb7
`define TXPH_CRC_INIT      16'hffff
`define TXPH_PREAMBLE_BYTE 8'haa
`define TXPH_PREAMBLE_NUM  3'h4
`define TXPH_SYNC_HI       8'h2d
`define TXPH_SYNC_LO       8'hd4
`define TXPH_SYNC_NUM      3'h2
`define TXPH_CRC_NUM       3'h2
`define TXPH_BIT_RATE_HZ   1000000
`define TXPH_CLK_HZ        40000000
`define TXPH_BIT_DIV       (`TXPH_CLK_HZ / `TXPH_BIT_RATE_HZ)
`define TXPH_FIFO_DEPTH    8
`define TXPH_BYTE_W        8

`endif

/* txph_pkg.sv */
// Types shared by the transmit packet-handler control slice.
// Assumes txph_params.svh sits in the same folder.
`include "txph_params.svh"

package txph_pkg;
    typedef logic [7:0]  txph_byte_t;
    typedef logic [15:0] txph_crc_t;
    typedef enum logic [2:0] {
        TXPH_IDLE, TXPH_PRE, TXPH_SYNC, TXPH_PAY, TXPH_CRC, TXPH_RAW, TXPH_DONE
    } txph_state_e;
endpackage : txph_pkg
